// ===== pkg/pause_tx_pkg.sv
// constants and types shared by the pause transmit control block
// assumes one transmit clock domain; no other package is required

package pause_tx_pkg;

    ////////////////////////////////////////////////////////////////////////
    // channel layout: eight priorities plus one global channel
    localparam int NUM_CH = 9;
    localparam int NUM_PRIO = 8;
    localparam logic [3:0] GLOBAL_CH = 4'h8;
    localparam int QUANTA_W = 16;
    localparam int CH_IDX_W = 4;

    // least time the requester holds each request bit, in tx clock cycles
    localparam int REQ_HOLD_CYCLES = 16;

    ////////////////////////////////////////////////////////////////////////
    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_ACTIVE = 8'h0C;
    localparam logic [7:0] OFF_PENDING = 8'h10;

    // field positions and reset values
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam logic [8:0] STATUS_RESET = 9'h000;
    localparam logic [8:0] MASK_RESET = 9'h000;

    ////////////////////////////////////////////////////////////////////////
    // frame launcher states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } send_state_t;

endpackage

// ===== core/refresh_timer.sv
// retransmission interval counter for one pause channel
// assumes run, restart and interval come from logic on ref_clk

`timescale 1ns/100ps
`default_nettype none

module refresh_timer (
    input wire logic ref_clk, // transmit clock
    input wire logic rst, // synchronous reset, active high
    input wire logic ce, // clock enable, freezes state when low
    input wire logic run, // channel is being requested
    input wire logic restart, // count again from zero
    input wire logic [15:0] interval, // cycles between refreshes, 0 = off
    output logic expire // one-cycle pulse when interval elapsed
);

    typedef struct packed {
        logic [15:0] count;
        logic expire;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // counting; a zero interval disables refresh rather than spinning
    always_comb begin
        next_s = s;
        next_s.expire = 1'b0;
        if (restart || !run) begin
            next_s.count = 16'h0000;
        end else if (interval != 16'h0000) begin
            if (s.count >= 16'(interval - 16'h0001)) begin
                next_s.count = 16'h0000;
                next_s.expire = 1'b1;
            end else begin
                next_s.count = 16'(s.count + 16'h0001);
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign expire = s.expire;

endmodule

`default_nettype wire

// ===== core/pause_frame_tx_control.sv
// transmit pause control: turns per-channel pause requests into pause
// frame launches towards the mac transmitter, with periodic refresh
// assumes all inputs are on ref_clk and the mac reports frame completion
// register map, all fields in the low bits, upper bits read as zero:
//   control at offset 0x00, bit 0 enables new launches
//   status at 0x04, sticky sent bits, write one to clear
//   mask at 0x08, selects which status bits drive irq
//   active at 0x0C, registered request levels, read only
//   pending at 0x10, channels queued for a frame, read only
// launch timing: a request sampled at one edge is queued at that same edge,
// and the frame port rises one edge after that; valid falls the edge
// after done, together with the sent pulse and the status bit
// limitations: no back-pressure towards the requester, and a frame
// already handed to the mac is never cancelled when its request drops
// all inputs are on ref_clk: there are no synchronisers, so the mac
// and the requester must share this clock
// the clock enable freezes timers too, so refresh spacing is counted
// in enabled cycles only

`timescale 1ns/100ps
`default_nettype none

module pause_frame_tx_control (
    input wire logic ref_clk, // transmit clock, 50 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic ce, // clock enable, freezes state when low
    input wire logic [8:0] tx_pause_request, // per-channel pause request
    input wire logic [15:0] tx_pause_quanta_prio0, // quanta, priority 0
    input wire logic [15:0] tx_pause_quanta_prio1, // quanta, priority 1
    input wire logic [15:0] tx_pause_quanta_prio2, // quanta, priority 2
    input wire logic [15:0] tx_pause_quanta_prio3, // quanta, priority 3
    input wire logic [15:0] tx_pause_quanta_prio4, // quanta, priority 4
    input wire logic [15:0] tx_pause_quanta_prio5, // quanta, priority 5
    input wire logic [15:0] tx_pause_quanta_prio6, // quanta, priority 6
    input wire logic [15:0] tx_pause_quanta_prio7, // quanta, priority 7
    input wire logic [15:0] tx_pause_quanta_global, // quanta, global
    input wire logic [15:0] tx_pause_refresh_interval_prio0, // refresh, p0
    input wire logic [15:0] tx_pause_refresh_interval_prio1, // refresh, p1
    input wire logic [15:0] tx_pause_refresh_interval_prio2, // refresh, p2
    input wire logic [15:0] tx_pause_refresh_interval_prio3, // refresh, p3
    input wire logic [15:0] tx_pause_refresh_interval_prio4, // refresh, p4
    input wire logic [15:0] tx_pause_refresh_interval_prio5, // refresh, p5
    input wire logic [15:0] tx_pause_refresh_interval_prio6, // refresh, p6
    input wire logic [15:0] tx_pause_refresh_interval_prio7, // refresh, p7
    input wire logic [15:0] tx_pause_refresh_interval_global, // refresh, glob
    input wire logic tx_pause_resend_pulse, // re-send frames of all active requests
    output logic [8:0] tx_pause_sent, // one-cycle pulse per sent frame
    input wire logic tx_frame_in_flight, // mac is sending another packet
    output logic pause_frame_valid, // pause frame requested from mac
    output logic pause_frame_global, // frame is a global pause
    output logic [2:0] pause_frame_prio, // priority of a priority frame
    output logic [15:0] pause_frame_quanta, // quanta to place in frame
    input wire logic pause_frame_done, // mac finished the pause frame
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    output logic irq // level interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // state of the block in one record, except the refresh timer counters
    // st: launcher state; req_q: request sampled last edge
    // due: channels queued; cur: channel of the frame on the port
    // frame_*: frame port outputs, held until done
    // sent: one-cycle sent pulses; status and mask: interrupt pair
    // rdata: read data, zero outside the read cycle
    typedef struct packed {
        pause_tx_pkg::send_state_t st;
        logic [8:0] req_q;
        logic [8:0] due;
        logic [3:0] cur;
        logic frame_valid;
        logic frame_global;
        logic [2:0] frame_prio;
        logic [15:0] frame_quanta;
        logic [8:0] sent;
        logic enable;
        logic [8:0] status;
        logic [8:0] mask;
        logic [31:0] rdata;
        logic irq;
    } ctl_state_t;

    ctl_state_t s;
    ctl_state_t next_s;

    // per-channel views of the inputs and timer handshakes
    logic [8:0][15:0] quanta_arr;
    logic [8:0][15:0] interval_arr;
    logic [8:0] expire;
    logic [8:0] restart;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    // register address match, shared by the read and write decode
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction

    // fixed order rather than round robin: the global frame halts all
    // traffic, so it must never wait behind a priority frame; a busy
    // low index can still starve a higher index until it drops
    // global first, then the lowest priority index
    function automatic logic [3:0] pick_channel(input logic [8:0] due);
        logic [3:0] ch;
        ch = 4'h0;
        for (int i = pause_tx_pkg::NUM_PRIO - 1; i >= 0; i--) begin
            if (due[i]) begin
                ch = 4'(i);
            end
        end
        if (due[pause_tx_pkg::GLOBAL_CH]) begin
            ch = pause_tx_pkg::GLOBAL_CH;
        end
        pick_channel = ch;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // packed arrays let the launcher index quanta by channel number
    // per-channel inputs gathered into arrays, index 8 is the global one
    assign quanta_arr = {tx_pause_quanta_global,
                         tx_pause_quanta_prio7, tx_pause_quanta_prio6,
                         tx_pause_quanta_prio5, tx_pause_quanta_prio4,
                         tx_pause_quanta_prio3, tx_pause_quanta_prio2,
                         tx_pause_quanta_prio1, tx_pause_quanta_prio0};
    assign interval_arr = {tx_pause_refresh_interval_global,
                           tx_pause_refresh_interval_prio7,
                           tx_pause_refresh_interval_prio6,
                           tx_pause_refresh_interval_prio5,
                           tx_pause_refresh_interval_prio4,
                           tx_pause_refresh_interval_prio3,
                           tx_pause_refresh_interval_prio2,
                           tx_pause_refresh_interval_prio1,
                           tx_pause_refresh_interval_prio0};

    ////////////////////////////////////////////////////////////////////////
    // one refresh timer per channel; the counter restarts on a new
    // request, on each launch of its frame, and on a resend pulse
    // a zero interval keeps the timer idle, so a channel without refresh
    // is sent once per request edge and once per resend pulse only
    genvar gi;
    generate
        for (gi = 0; gi < pause_tx_pkg::NUM_CH; gi++) begin : g_timer
            assign restart[gi] = tx_pause_resend_pulse
                || (tx_pause_request[gi] && !s.req_q[gi])
                || (s.st == pause_tx_pkg::ST_IDLE && next_s.frame_valid
                    && next_s.cur == 4'(gi));
            refresh_timer u_timer (
                .ref_clk(ref_clk),
                .rst(rst),
                .ce(ce),
                .run(s.req_q[gi]),
                .restart(restart[gi]),
                .interval(interval_arr[gi]),
                .expire(expire[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [8:0] rise;
        logic [8:0] due_set;
        logic [8:0] launch_mask;
        logic [3:0] ch;
        next_s = s;
        rise = 9'h000;
        due_set = 9'h000;
        launch_mask = 9'h000;
        ch = 4'h0;
        next_s.sent = 9'h000;
        next_s.req_q = tx_pause_request;

        // a fresh request, an elapsed interval or a resend queue a frame;
        // the requester's minimum hold time makes one edge per request
        rise = tx_pause_request & ~s.req_q;
        due_set = rise | (expire & s.req_q);
        if (tx_pause_resend_pulse) begin
            due_set = due_set | s.req_q;
        end

        // the pick is made from the registered queue, so a request seen
        // this edge can launch no earlier than the next one; this costs a
        // cycle but keeps the priority encoder off the input path
        // launcher: never preempts a packet already on the wire
        case (s.st)
            pause_tx_pkg::ST_IDLE: begin
                if (s.enable && !tx_frame_in_flight && (s.due != 9'h000)) begin
                    ch = pick_channel(s.due);
                    launch_mask = 9'h001 << ch;
                    next_s.cur = ch;
                    next_s.frame_valid = 1'b1;
                    next_s.frame_global = (ch == pause_tx_pkg::GLOBAL_CH);
                    next_s.frame_prio = ch[2:0];
                    next_s.frame_quanta = quanta_arr[ch];
                    next_s.st = pause_tx_pkg::ST_BUSY;
                end
            end
            pause_tx_pkg::ST_BUSY: begin
                // done is only honoured while the frame stands on the port
                if (pause_frame_done) begin
                    next_s.sent[s.cur] = 1'b1;
                    next_s.frame_valid = 1'b0;
                    next_s.st = pause_tx_pkg::ST_IDLE;
                end
            end
            default: begin
                // unreachable with one state bit, kept for safety
                next_s.st = pause_tx_pkg::ST_IDLE;
                next_s.frame_valid = 1'b0;
            end
        endcase

        // a set in the launch cycle survives; a dropped request wins
        next_s.due = ((s.due & ~launch_mask) | due_set)
                     & tx_pause_request;

        // writes act at the edge that samples the strobe; an unmapped
        // offset matches nothing and is silently dropped
        // register writes; status is write-one-to-clear
        next_s.status = s.status;
        if (reg_wr) begin
            if (reg_hit(reg_addr, pause_tx_pkg::OFF_CTRL)) begin
                next_s.enable = reg_wdata[pause_tx_pkg::CTRL_ENABLE_BIT];
            end
            if (reg_hit(reg_addr, pause_tx_pkg::OFF_STATUS)) begin
                next_s.status = s.status & ~reg_wdata[8:0];
            end
            if (reg_hit(reg_addr, pause_tx_pkg::OFF_MASK)) begin
                next_s.mask = reg_wdata[8:0];
            end
        end
        // hardware set beats a clear in the same cycle
        next_s.status = next_s.status | next_s.sent;

        // unmapped offsets read as zero so software can probe the map
        // read data valid only in the cycle after the strobe
        next_s.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_hit(reg_addr, pause_tx_pkg::OFF_CTRL)) begin
                next_s.rdata[pause_tx_pkg::CTRL_ENABLE_BIT] = s.enable;
            end else if (reg_hit(reg_addr, pause_tx_pkg::OFF_STATUS)) begin
                next_s.rdata[8:0] = s.status;
            end else if (reg_hit(reg_addr, pause_tx_pkg::OFF_MASK)) begin
                next_s.rdata[8:0] = s.mask;
            end else if (reg_hit(reg_addr, pause_tx_pkg::OFF_ACTIVE)) begin
                next_s.rdata[8:0] = s.req_q;
            end else if (reg_hit(reg_addr, pause_tx_pkg::OFF_PENDING)) begin
                next_s.rdata[8:0] = s.due;
            end
        end

        // irq follows the next state so it moves with status and mask
        next_s.irq = |(next_s.status & next_s.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // reset ignores the clock enable so a frozen block can still be
    // brought back to a known state; enable comes back set so requests
    // work without any register access
    // state register; clock enable freezes everything
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
            s.enable <= pause_tx_pkg::CTRL_ENABLE_RESET;
            s.status <= pause_tx_pkg::STATUS_RESET;
            s.mask <= pause_tx_pkg::MASK_RESET;
        end else if (ce) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // nothing here is combinational, so the mac and the register master
    // see clean flop outputs with a full cycle of slack
    // outputs, all straight from the state register
    assign tx_pause_sent = s.sent;
    assign pause_frame_valid = s.frame_valid;
    assign pause_frame_global = s.frame_global;
    assign pause_frame_prio = s.frame_prio;
    assign pause_frame_quanta = s.frame_quanta;
    assign reg_rdata = s.rdata;
    assign irq = s.irq;

endmodule

`default_nettype wire

// ===== dv/pause_tx_checker_assertions.sv
// assertions on the ports of the pause transmit control block
// assumes one clock, reset synchronous and active high
`timescale 1ns/100ps
`default_nettype none
module pause_tx_checker (
    input wire logic ref_clk, // transmit clock
    input wire logic rst, // synchronous reset
    input wire logic [15:0] tx_pause_quanta_global, // global quanta
    input wire logic tx_frame_in_flight, // mac busy
    input wire logic pause_frame_valid, // frame asked for
    input wire logic pause_frame_global, // global frame
    input wire logic [2:0] pause_frame_prio, // frame priority
    input wire logic [15:0] pause_frame_quanta, // frame quanta
    input wire logic pause_frame_done, // mac finished
    input wire logic [8:0] tx_pause_sent, // sent pulses
    input wire logic reg_rd, // read strobe
    input wire logic [31:0] reg_rdata // read data
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [8:0] chan_bit;
    // bit a finished frame must report
    assign chan_bit = pause_frame_global ? 9'h100 : 9'h001 << pause_frame_prio;
    ////////////////////////////////////////////////////////////////////////
    chk_sent_channel: assert property (
        pause_frame_valid && pause_frame_done
        |=> !pause_frame_valid && tx_pause_sent == $past(chan_bit))
        else $error("sent bit does not match finished frame");
    chk_sent_cause: assert property (
        tx_pause_sent != 9'h000
        |-> $past(pause_frame_valid) && $past(pause_frame_done))
        else $error("sent pulse without finished frame");
    chk_one_channel: assert property (
        tx_pause_sent != 9'h000 |-> $onehot(tx_pause_sent))
        else $error("more than one sent bit");
    chk_global_quanta: assert property (
        $rose(pause_frame_valid) && pause_frame_global
        |-> pause_frame_quanta == $past(tx_pause_quanta_global))
        else $error("global frame quanta wrong");
    chk_global_prio: assert property (
        pause_frame_valid && pause_frame_global |-> pause_frame_prio == 3'h0)
        else $error("global frame carries a priority");
    chk_wait_flight: assert property (
        !pause_frame_valid && tx_frame_in_flight |=> !pause_frame_valid)
        else $error("launch while packet in flight");
    chk_frame_stands: assert property (
        pause_frame_valid && !pause_frame_done
        |=> pause_frame_valid && $stable(pause_frame_quanta)
            && $stable(pause_frame_prio))
        else $error("frame changed before done");
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    cover property ($rose(pause_frame_valid) && pause_frame_global);
    cover property (tx_frame_in_flight && !pause_frame_valid);
    cover property (tx_pause_sent != 9'h000);
endmodule
bind pause_frame_tx_control pause_tx_checker chk_u (
    .ref_clk(ref_clk), .rst(rst),
    .tx_pause_quanta_global(tx_pause_quanta_global),
    .tx_frame_in_flight(tx_frame_in_flight),
    .pause_frame_valid(pause_frame_valid),
    .pause_frame_global(pause_frame_global),
    .pause_frame_prio(pause_frame_prio),
    .pause_frame_quanta(pause_frame_quanta),
    .pause_frame_done(pause_frame_done), .tx_pause_sent(tx_pause_sent),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// ===== dv/mac_tx_model.sv
// behavioural mac transmitter facing the pause frame port
// assumes the bench picks the latency and when a data packet runs
`timescale 1ns/100ps
`default_nettype none
module mac_tx_model (
    input wire logic ref_clk, // transmit clock
    input wire logic rst, // synchronous reset
    input wire logic pause_frame_valid, // frame asked for
    input wire logic [3:0] lat, // cycles from valid to done, at least 1
    input wire logic busy, // bench wants a data packet on the wire
    output logic pause_frame_done, // frame finished pulse
    output logic tx_frame_in_flight // data packet being sent
);
    logic [3:0] cnt;
    // done is one cycle long so a frame is never finished twice
    always_ff @(posedge ref_clk) begin
        tx_frame_in_flight <= busy & ~rst;
        if (rst || !pause_frame_valid || pause_frame_done) begin
            cnt <= 4'h0;
            pause_frame_done <= 1'b0;
        end else if (cnt == lat - 4'h1) begin
            pause_frame_done <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== dv/pause_frame_tx_control_tb_top.sv
// self-checking bench for the pause transmit control block
// assumes the mac model answers the frame port
`timescale 1ns/100ps
`default_nettype none
module pause_frame_tx_control_tb_top;
    typedef struct {logic [3:0] ch; logic [15:0] qv; logic g; logic [2:0] p;}
        row_t;
    // channel, its quanta, and the frame kind it should give
    row_t rows [0:8] = '{
        '{4'h8, 16'hFFFF, 1'b1, 3'h0}, '{4'h0, 16'h0001, 1'b0, 3'h0},
        '{4'h1, 16'h8000, 1'b0, 3'h1}, '{4'h2, 16'h1234, 1'b0, 3'h2},
        '{4'h3, 16'h00FF, 1'b0, 3'h3}, '{4'h4, 16'hA5A5, 1'b0, 3'h4},
        '{4'h5, 16'h0000, 1'b0, 3'h5}, '{4'h6, 16'h7FFF, 1'b0, 3'h6},
        '{4'h7, 16'hC003, 1'b0, 3'h7}};
    logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, resend = 1'b0;
    logic busy = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] lat = 4'h2;
    logic [8:0] req = 9'h000;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [15:0] q [0:8];
    logic [15:0] iv [0:8] = '{default: 16'h0000};
    logic valid, glob, done, infl, irq;
    logic [2:0] prio;
    logic [15:0] quanta;
    logic [8:0] sent;
    logic [31:0] rdata;
    int errors = 0, tests_run = 0, cyc = 0, t0, t1;
    pause_frame_tx_control dut_u (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .tx_pause_request(req),
        .tx_pause_quanta_prio0(q[0]), .tx_pause_quanta_prio1(q[1]),
        .tx_pause_quanta_prio2(q[2]), .tx_pause_quanta_prio3(q[3]),
        .tx_pause_quanta_prio4(q[4]), .tx_pause_quanta_prio5(q[5]),
        .tx_pause_quanta_prio6(q[6]), .tx_pause_quanta_prio7(q[7]),
        .tx_pause_quanta_global(q[8]),
        .tx_pause_refresh_interval_prio0(iv[0]),
        .tx_pause_refresh_interval_prio1(iv[1]),
        .tx_pause_refresh_interval_prio2(iv[2]),
        .tx_pause_refresh_interval_prio3(iv[3]),
        .tx_pause_refresh_interval_prio4(iv[4]),
        .tx_pause_refresh_interval_prio5(iv[5]),
        .tx_pause_refresh_interval_prio6(iv[6]),
        .tx_pause_refresh_interval_prio7(iv[7]),
        .tx_pause_refresh_interval_global(iv[8]),
        .tx_pause_resend_pulse(resend), .tx_pause_sent(sent),
        .tx_frame_in_flight(infl), .pause_frame_valid(valid),
        .pause_frame_global(glob), .pause_frame_prio(prio),
        .pause_frame_quanta(quanta), .pause_frame_done(done),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .irq(irq));
    mac_tx_model mac_u (.ref_clk(ref_clk), .rst(rst), .pause_frame_valid(valid),
        .lat(lat), .busy(busy), .pause_frame_done(done),
        .tx_frame_in_flight(infl));
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // bounded waits, a hang shows as a mismatch
    task automatic wait_valid();
        int n = 0;
        while (valid !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        check("launch", 1, n < 300);
        t0 = cyc;
    endtask
    task automatic wait_sent(input logic [8:0] e);
        int n = 0;
        while (sent === 9'h000 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        check("sent", e, sent);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        check("register", e, rdata);
        @(posedge ref_clk);
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        results();
    end
    initial begin
        for (int r = 0; r < 9; r++) q[rows[r].ch] = rows[r].qv;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        for (int r = 0; r < 9; r++) begin
            req[rows[r].ch] <= 1'b1;
            wait_valid();
            check("global", rows[r].g, glob);
            check("prio", rows[r].p, prio);
            check("quanta", rows[r].qv, quanta);
            wait_sent(9'h001 << rows[r].ch);
            repeat (16) @(posedge ref_clk);
            req[rows[r].ch] <= 1'b0;
            repeat (16) @(posedge ref_clk);
        end
        // sticky sent bits, mask and write-one-to-clear
        reg_read(pause_tx_pkg::OFF_CTRL, 32'h1);
        reg_read(pause_tx_pkg::OFF_STATUS, 32'h1FF);
        reg_read(8'hFC, 32'h0);
        check("irq masked", 0, irq);
        reg_write(pause_tx_pkg::OFF_MASK, 32'h100);
        reg_read(pause_tx_pkg::OFF_MASK, 32'h100);
        check("irq on", 1, irq);
        reg_write(pause_tx_pkg::OFF_STATUS, 32'h0FF);
        check("irq kept", 1, irq);
        reg_write(pause_tx_pkg::OFF_STATUS, 32'h100);
        reg_read(pause_tx_pkg::OFF_STATUS, 32'h0);
        check("irq off", 0, irq);
        // refresh spacing, then a resend restarts the interval
        iv[5] <= 16'h0028;
        req[5] <= 1'b1;
        wait_valid();
        t1 = t0;
        wait_sent(9'h020);
        wait_valid();
        check("refresh gap", 1, t0 - t1 >= 40 && t0 - t1 <= 43);
        repeat (20) @(posedge ref_clk);
        resend <= 1'b1;
        t1 = cyc;
        @(posedge ref_clk);
        resend <= 1'b0;
        wait_valid();
        check("resend prompt", 1, t0 - t1 <= 4);
        t1 = t0;
        wait_sent(9'h020);
        wait_valid();
        check("restart gap", 1, t0 - t1 >= 40 && t0 - t1 <= 43);
        wait_sent(9'h020);
        req[5] <= 1'b0;
        t1 = 0;
        repeat (120) begin
            @(posedge ref_clk);
            if (valid === 1'b1) t1++;
        end
        check("stopped", 0, t1);
        // resend held back by a packet in flight, slow mac
        lat <= 4'h6;
        req[6] <= 1'b1;
        wait_valid();
        wait_sent(9'h040);
        busy <= 1'b1;
        resend <= 1'b1;
        @(posedge ref_clk);
        resend <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check("held", 0, valid);
        busy <= 1'b0;
        wait_valid();
        check("resent prio", 6, prio);
        wait_sent(9'h040);
        // disabled launcher keeps the queue, a frozen block drops writes
        reg_write(pause_tx_pkg::OFF_CTRL, 32'h0);
        req[7] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reg_read(pause_tx_pkg::OFF_ACTIVE, 32'h0C0);
        reg_read(pause_tx_pkg::OFF_PENDING, 32'h080);
        check("disabled", 0, valid);
        ce <= 1'b0;
        reg_write(pause_tx_pkg::OFF_CTRL, 32'h1);
        ce <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("frozen", 0, valid);
        reg_write(pause_tx_pkg::OFF_CTRL, 32'h1);
        wait_valid();
        check("prio 7", 7, prio);
        check("quanta 7", 16'hC003, quanta);
        wait_sent(9'h080);
        // reset in mid-run clears status; enable, already set, reads back set
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("reset valid", 0, valid);
        rst <= 1'b0;
        reg_read(pause_tx_pkg::OFF_STATUS, 32'h0);
        reg_read(pause_tx_pkg::OFF_CTRL, 32'h1);
        results();
    end
endmodule
`default_nettype wire
